// >>> hw/rsc_pkg.sv
// Shared constants, codes and types of the rate sensor serial command unit
package rsc_pkg;

   // ***********************************************************
   // Command codes, unlock addresses and fixed answers
   // ***********************************************************
   localparam logic [7:0] CMD_RATE_HIGH_READ  = 8'h80;
   localparam logic [7:0] CMD_RATE_LOW_READ   = 8'h8F;
   localparam logic [7:0] CMD_STATUS_READ     = 8'hB4;
   localparam logic [7:0] CMD_HIGHPASS_INIT   = 8'hC4;
   localparam logic [7:0] CMD_UNLOCK_ONE      = 8'h4E;
   localparam logic [7:0] CMD_UNLOCK_TWO      = 8'h63;
   localparam logic [7:0] CMD_UNLOCK_THREE    = 8'h12;
   localparam logic [7:0] CMD_LOCK_ENABLE     = 8'h55;
   localparam logic [7:0] CMD_PROC_REENABLE   = 8'hAA;
   localparam logic [7:0] ADDR_UNLOCK_ONE     = 8'hD7;
   localparam logic [7:0] ADDR_UNLOCK_TWO     = 8'h50;
   localparam logic [7:0] ADDR_UNLOCK_THREE   = 8'hA8;
   localparam logic [7:0] RESP_ACK            = 8'h80;
   localparam logic [7:0] RESP_ERROR          = 8'h80;
   localparam logic [5:0] RESP_LOW_PREFIX     = 6'h15;
   localparam logic [7:0] STATUS_ALL_OK       = 8'hFF;

   // ***********************************************************
   // Frame geometry and reset values
   // ***********************************************************
   localparam logic [4:0] CMD_BITS            = 5'h08;
   localparam logic [4:0] ADDR_CMD_BITS       = 5'h10;
   localparam logic       LOCK_RESET          = 1'b1;
   localparam logic [7:0] RESP_RESET          = 8'h80;

   // ***********************************************************
   // Rate format and filter coefficients (Q12 biquads)
   // ***********************************************************
   localparam int                RATE_W       = 10;
   localparam logic signed [9:0] RATE_MAX     = 10'h1FC;
   localparam logic signed [9:0] RATE_MIN     = -10'sh1FC;
   localparam int                LP_FRAC      = 12;
   localparam logic signed [17:0] LP_A11 = 18'h01E92;
   localparam logic signed [17:0] LP_A21 = -18'sh00EE8;
   localparam logic signed [17:0] LP_B01 = 18'h0002B;
   localparam logic signed [17:0] LP_B11 = -18'sh0002B;
   localparam logic signed [17:0] LP_B21 = 18'h0002B;
   localparam logic signed [17:0] LP_A12 = 18'h01D47;
   localparam logic signed [17:0] LP_A22 = -18'sh00D71;
   localparam logic signed [17:0] LP_B02 = 18'h00020;
   localparam logic signed [17:0] LP_B12 = 18'h00014;
   localparam logic signed [17:0] LP_B22 = 18'h00020;
   localparam real HP_FL_HZ = 0.01;
   localparam real HP_FS_HZ = 2000.0;
   localparam int  HP_FRAC  = 24;
   localparam real HP_X     = HP_FL_HZ / (2.0 * HP_FS_HZ);
   localparam logic signed [25:0] HP_P0 =
      26'(int'((1.0 - HP_X) / (1.0 + HP_X) * (2.0 ** HP_FRAC)));

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {USTEP_ONE, USTEP_TWO, USTEP_THREE} rsc_ustep_t;

   typedef struct packed {
      logic sclk;
      logic load;
      logic mosi;
   } rsc_pins_t;

   typedef struct packed {
      logic d;
      logic oe;
   } rsc_miso_t;

endpackage

// >>> hw/rsc_fifo.sv
// Small flop based FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rsc_fifo
   import rsc_pkg::*;
   #(parameter int W = 10,
     parameter int D = 4)
   (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // Fill side
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
   );

   localparam int AW = $clog2(D);

   if (D < 2 || (D & (D - 1)) != 0 || W < 1)
   begin : g_chk
      $error("rsc_fifo: depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
   } rsc_fifo_st_t;

   rsc_fifo_st_t q_r;
   rsc_fifo_st_t q_nxt;
   logic         push;
   logic         pop;

   assign in_ready  = (q_r.cnt != (AW+1)'(D));
   assign out_valid = (q_r.cnt != '0);
   assign out_data  = q_r.mem[q_r.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      q_nxt = q_r;
      if (push)
      begin
         q_nxt.mem[q_r.wr] = in_data;
         q_nxt.wr          = q_r.wr + 1'b1;
      end
      if (pop)
      begin
         q_nxt.rd = q_r.rd + 1'b1;
      end
      case ({push, pop})
         2'b10:   q_nxt.cnt = q_r.cnt + 1'b1;
         2'b01:   q_nxt.cnt = q_r.cnt - 1'b1;
         default: q_nxt.cnt = q_r.cnt;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

endmodule // rsc_fifo
`default_nettype wire

// >>> hw/rsc_cmd_unit.sv
// Serial command unit of the angular rate sensor: frame decode and filter
//
// What this block does
// - High read returns rate bits nine to two
// - Low read returns 010101 and bits one, zero
// - Status read returns the status flag byte
// - High read latches low bits of same sample
// - Filter init takes level address, needs unlock
// - Three addressed unlock commands disable the lock
// - Stray command or bad address restarts unlock
// - Lock enable command relocks, acknowledged
// - Re-enable clears recoverable error, needs unlock
// - Error answer is fixed 1000 0000
// - Rate reads answer error before filter init
// - Illegal command answers the error pattern
// - Any status flag low gives error
// - Valid rate clipped to plus minus 508
// - Rate is 10-bit two's complement, 1/dps
// - Full scale reads 7F/54 and 81/54
// - Zero rate reads 00 and 54
// - First order high-pass, zero at one
// - Two fixed second order low-pass sections
// - Data output undriven while strobe high
// - Sample on rising, shift out on falling
// - Execute on strobe rise, discard short frames
`timescale 1ns/100ps
`default_nettype none
module rsc_cmd_unit
   import rsc_pkg::*;
   #(parameter int FIFO_DEPTH = 4)
   (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              resetn,
   // Serial link pins
   input  wire rsc_pins_t         pins,
   output rsc_miso_t              miso,
   // Raw sample stream at the sampling rate
   input  wire logic signed [15:0] raw_sample,
   input  wire logic              raw_valid,
   output logic                   raw_ready,
   // Monitoring and start-up
   input  wire logic [7:0]        status_flags,
   input  wire logic              startup_done,
   input  wire logic              rec_error_evt,
   // State shown to the chip
   output logic                   lock_enabled,
   output logic                   highpass_init_hold,
   output logic                   rec_error
   );

   if (FIFO_DEPTH < 2)
   begin : g_chk
      $error("rsc_cmd_unit: FIFO_DEPTH must be at least 2");
   end

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [2:0]         sclk_s;
      logic [2:0]         load_s;
      logic [2:0]         mosi_s;
      logic               sclk_f;
      logic               load_f;
      logic               mosi_f;
      logic [15:0]        shin;
      logic [4:0]         cnt;
      logic [7:0]         shout;
      logic [7:0]         resp;
      logic               oe;
      logic               lock_en;
      rsc_ustep_t         ustep;
      logic               init_done;
      logic               hp_hold;
      logic               err_rec;
      logic [RATE_W-1:0]  rate;
      logic [1:0]         low_bits;
      logic signed [31:0] hp_x1;
      logic signed [31:0] hp_y1;
      logic signed [31:0] s1_x1;
      logic signed [31:0] s1_x2;
      logic signed [31:0] s1_y1;
      logic signed [31:0] s1_y2;
      logic signed [31:0] s2_y1;
      logic signed [31:0] s2_y2;
   } rsc_state_t;

   rsc_state_t        q_r;
   rsc_state_t        q_nxt;

   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_pop;
   logic [RATE_W-1:0] fifo_out_data;
   logic [RATE_W-1:0] new_rate;
   logic              fire;
   logic signed [31:0] hp_y;
   logic signed [31:0] s1_y;
   logic signed [31:0] s2_y;
   logic signed [56:0] hp_acc;

   // ***********************************************************
   // Arithmetic helpers
   // ***********************************************************
   // One second order section, direct form I, Q12 coefficients
   function automatic logic signed [31:0] biquad
      (input logic signed [31:0] x,
       input logic signed [31:0] x1,
       input logic signed [31:0] x2,
       input logic signed [31:0] y1,
       input logic signed [31:0] y2,
       input logic signed [17:0] b0,
       input logic signed [17:0] b1,
       input logic signed [17:0] b2,
       input logic signed [17:0] a1,
       input logic signed [17:0] a2);
      logic signed [53:0] acc;
      acc = b0 * x + b1 * x1 + b2 * x2 + a1 * y1 + a2 * y2;
      return acc[LP_FRAC+31:LP_FRAC];
   endfunction

   // Clip to the valid rate window so the error word never appears
   function automatic logic [RATE_W-1:0] clip_rate
      (input logic signed [31:0] v);
      if (v > 32'(RATE_MAX))
         return RATE_MAX;
      else if (v < 32'(RATE_MIN))
         return RATE_MIN;
      else
         return v[RATE_W-1:0];
   endfunction

   // ***********************************************************
   // Filter chain
   // ***********************************************************
   assign fire = raw_valid & fifo_in_ready;

   always_comb
   begin
      hp_acc = (57'(32'(raw_sample) - q_r.hp_x1) <<< HP_FRAC)
               + 57'(HP_P0 * q_r.hp_y1);
      hp_y   = hp_acc[HP_FRAC+31:HP_FRAC];
      s1_y   = biquad(hp_y, q_r.s1_x1, q_r.s1_x2, q_r.s1_y1,
                      q_r.s1_y2, LP_B01, LP_B11, LP_B21,
                      LP_A11, LP_A21);
      s2_y   = biquad(s1_y, q_r.s1_y1, q_r.s1_y2, q_r.s2_y1,
                      q_r.s2_y2, LP_B02, LP_B12, LP_B22,
                      LP_A12, LP_A22);
      new_rate = clip_rate(s2_y);
   end

   rsc_fifo
      #(.W (RATE_W),
        .D (FIFO_DEPTH))
   u_fifo
      (.mclk      (mclk),
       .resetn    (resetn),
       .in_valid  (raw_valid),
       .in_ready  (fifo_in_ready),
       .in_data   (new_rate),
       .out_valid (fifo_out_valid),
       .out_ready (q_r.load_f),
       .out_data  (fifo_out_data));

   // Samples are only taken over while no frame is open
   assign fifo_pop  = fifo_out_valid & q_r.load_f;
   assign raw_ready = fifo_in_ready;

   // ***********************************************************
   // Frame handling and command execution
   // ***********************************************************
   always_comb
   begin
      logic       sclk_n;
      logic       load_n;
      logic       mosi_n;
      logic       sclk_rise;
      logic       sclk_fall;
      logic       load_rise;
      logic       load_fall;
      logic [7:0] cmd;
      logic [7:0] addr;
      logic       has_addr;
      logic       rd_err;
      logic       unlocked;
      sclk_n    = q_r.sclk_f;
      load_n    = q_r.load_f;
      mosi_n    = q_r.mosi_f;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      load_rise = 1'b0;
      load_fall = 1'b0;
      cmd       = q_r.shin[7:0];
      addr      = q_r.shin[15:8];
      has_addr  = (q_r.cnt >= ADDR_CMD_BITS);
      rd_err    = ~q_r.init_done | q_r.hp_hold | q_r.err_rec
                  | (status_flags != STATUS_ALL_OK);
      unlocked  = ~q_r.lock_en;
      q_nxt     = q_r;

      // Three stage pin sampling; a level counts once the last two stages agree
      q_nxt.sclk_s = {q_r.sclk_s[1:0], pins.sclk};
      q_nxt.load_s = {q_r.load_s[1:0], pins.load};
      q_nxt.mosi_s = {q_r.mosi_s[1:0], pins.mosi};
      if (q_r.sclk_s[1] == q_r.sclk_s[2])
         sclk_n = q_r.sclk_s[2];
      if (q_r.load_s[1] == q_r.load_s[2])
         load_n = q_r.load_s[2];
      if (q_r.mosi_s[1] == q_r.mosi_s[2])
         mosi_n = q_r.mosi_s[2];
      q_nxt.sclk_f = sclk_n;
      q_nxt.load_f = load_n;
      q_nxt.mosi_f = mosi_n;
      sclk_rise = ~q_r.sclk_f & sclk_n;
      sclk_fall = q_r.sclk_f & ~sclk_n;
      load_rise = ~q_r.load_f & load_n;
      load_fall = q_r.load_f & ~load_n;

      q_nxt.oe = ~load_n;

      if (load_fall)
      begin
         q_nxt.shout = q_r.resp;
         q_nxt.cnt   = '0;
      end
      else if (~q_r.load_f)
      begin
         if (sclk_rise)
         begin
            q_nxt.shin = {q_r.shin[14:0], mosi_n};
            if (q_r.cnt != 5'h1F)
               q_nxt.cnt = q_r.cnt + 5'h01;
         end
         if (sclk_fall)
            q_nxt.shout = {q_r.shout[6:0], 1'b0};
      end

      // Filter state advance; held in init while requested
      if (fire)
      begin
         q_nxt.hp_x1 = 32'(raw_sample);
         q_nxt.hp_y1 = q_r.hp_hold ? 32'sh0 : hp_y;
         q_nxt.s1_x1 = q_r.hp_hold ? 32'sh0 : hp_y;
         q_nxt.s1_x2 = q_r.s1_x1;
         q_nxt.s1_y1 = s1_y;
         q_nxt.s1_y2 = q_r.s1_y1;
         q_nxt.s2_y1 = s2_y;
         q_nxt.s2_y2 = q_r.s2_y1;
      end
      if (fifo_pop)
         q_nxt.rate = fifo_out_data;

      if (startup_done & ~q_r.hp_hold)
         q_nxt.init_done = 1'b1;

      // Commands run on strobe rise; short frames are dropped
      if (load_rise && q_r.cnt >= CMD_BITS)
      begin
         q_nxt.ustep = USTEP_ONE;
         q_nxt.resp  = RESP_ERROR;
         case (cmd)
            CMD_RATE_HIGH_READ:
            begin
               q_nxt.low_bits = q_r.rate[1:0];
               q_nxt.resp     = rd_err ? RESP_ERROR
                                       : q_r.rate[9:2];
            end
            CMD_RATE_LOW_READ:
               q_nxt.resp = rd_err ? RESP_ERROR
                            : {RESP_LOW_PREFIX, q_r.low_bits};
            CMD_STATUS_READ:
               q_nxt.resp = status_flags;
            CMD_HIGHPASS_INIT:
            begin
               if (unlocked && has_addr)
               begin
                  q_nxt.hp_hold = (addr != 8'h00);
                  if (addr == 8'h00)
                     q_nxt.init_done = 1'b1;
                  q_nxt.resp = RESP_ACK;
               end
            end
            CMD_UNLOCK_ONE:
            begin
               if (has_addr && addr == ADDR_UNLOCK_ONE)
               begin
                  q_nxt.ustep = USTEP_TWO;
                  q_nxt.resp  = RESP_ACK;
               end
            end
            CMD_UNLOCK_TWO:
            begin
               if (q_r.ustep == USTEP_TWO && has_addr
                   && addr == ADDR_UNLOCK_TWO)
               begin
                  q_nxt.ustep = USTEP_THREE;
                  q_nxt.resp  = RESP_ACK;
               end
            end
            CMD_UNLOCK_THREE:
            begin
               if (q_r.ustep == USTEP_THREE && has_addr
                   && addr == ADDR_UNLOCK_THREE)
               begin
                  q_nxt.lock_en = 1'b0;
                  q_nxt.resp    = RESP_ACK;
               end
            end
            CMD_LOCK_ENABLE:
            begin
               q_nxt.lock_en = 1'b1;
               q_nxt.resp    = RESP_ACK;
            end
            CMD_PROC_REENABLE:
            begin
               if (unlocked)
               begin
                  q_nxt.err_rec = 1'b0;
                  q_nxt.resp    = RESP_ACK;
               end
            end
            default:
               q_nxt.resp = RESP_ERROR;
         endcase
      end

      // A new error event wins over a clear in the same cycle
      if (rec_error_evt)
         q_nxt.err_rec = 1'b1;
   end

   // ***********************************************************
   // Registers
   // ***********************************************************
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         q_r         <= '0;
         q_r.sclk_s  <= 3'h0;
         q_r.load_s  <= 3'h7;
         q_r.load_f  <= 1'b1;
         q_r.mosi_f  <= 1'b0;
         q_r.resp    <= RESP_RESET;
         q_r.lock_en <= LOCK_RESET;
         q_r.ustep   <= USTEP_ONE;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign miso.d             = q_r.shout[7];
   assign miso.oe            = q_r.oe;
   assign lock_enabled       = q_r.lock_en;
   assign highpass_init_hold = q_r.hp_hold;
   assign rec_error          = q_r.err_rec;

endmodule // rsc_cmd_unit
`default_nettype wire

// >>> tb/rsc_cmd_unit_monitor.sv
// Port checks of the serial command unit
`timescale 1ns/100ps
`default_nettype none
module rsc_cmd_unit_monitor
   import rsc_pkg::*;
   (
   // Clock and reset
   input  wire logic      mclk,
   input  wire logic      resetn,
   // Serial link
   input  wire rsc_pins_t pins,
   input  wire rsc_miso_t miso,
   // Error event and state
   input  wire logic      rec_error_evt,
   input  wire logic      lock_enabled,
   input  wire logic      highpass_init_hold,
   input  wire logic      rec_error
   );
   // ****
   // Checks
   // ****
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   oe_idle_a: assert property (pins.load [*6] |-> !miso.oe)
      else $error("data output driven between frames");
   oe_frame_a: assert property (!pins.load [*6] |-> miso.oe)
      else $error("data output not driven in frame");
   bit_shift_a: assert property (miso.oe && $past(miso.oe)
      && $changed(miso.d) |-> !pins.sclk && !$past(pins.sclk, 2))
      else $error("data bit changed away from a falling clock");
   unlock_exec_a: assert property ($fell(lock_enabled)
      |-> pins.load && $past(pins.load, 2))
      else $error("lock released outside command execution");
   relock_exec_a: assert property ($rose(lock_enabled)
      |-> pins.load && $past(pins.load, 2))
      else $error("lock set outside command execution");
   err_set_a: assert property (rec_error_evt |=> rec_error)
      else $error("recoverable error not latched");
   err_clear_a: assert property ($fell(rec_error)
      |-> !$past(lock_enabled) && pins.load)
      else $error("error cleared while locked");
   hold_guard_a: assert property ($changed(highpass_init_hold)
      |-> !$past(lock_enabled) && pins.load)
      else $error("filter hold changed while locked");
endmodule // rsc_cmd_unit_monitor

bind rsc_cmd_unit rsc_cmd_unit_monitor i_mon (
   .mclk(mclk), .resetn(resetn), .pins(pins), .miso(miso),
   .rec_error_evt(rec_error_evt), .lock_enabled(lock_enabled),
   .highpass_init_hold(highpass_init_hold), .rec_error(rec_error));
`default_nettype wire

// >>> tb/rsc_spi_master.sv
// Serial master model driving the command unit link
`timescale 1ns/100ps
`default_nettype none
module rsc_spi_master
   import rsc_pkg::*;
   (
   // Clock
   input  wire logic      mclk,
   // Serial link
   output var rsc_pins_t  pins,
   input  wire rsc_miso_t miso,
   // Answer seen in the last frame
   output logic [7:0]     rx_byte,
   output logic           rx_stb
   );
   // ****
   // Frame transfer, clock idles low
   // ****
   initial
   begin
      pins = '{sclk: 1'b0, load: 1'b1, mosi: 1'b0};
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end

   task automatic xfer(input logic [15:0] w, input int n);
      logic [7:0] rx;
      rx = 8'h00;
      @(posedge mclk) pins.load <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         pins.mosi <= w[i];
         repeat (10) @(posedge mclk);
         pins.sclk <= 1'b1;
         // Previous answer comes out during the first byte only
         if (i >= n - 8)
            rx = {rx[6:0], miso.d};
         repeat (10) @(posedge mclk);
         pins.sclk <= 1'b0;
      end
      repeat (10) @(posedge mclk);
      pins.load <= 1'b1;
      pins.mosi <= ~pins.mosi;
      rx_byte <= rx;
      rx_stb <= (n >= 8);
      @(posedge mclk) rx_stb <= 1'b0;
      repeat (70) @(posedge mclk);
   endtask
endmodule // rsc_spi_master
`default_nettype wire

// >>> tb/tb_rsc_cmd_unit.sv
// Self-checking bench of the serial command unit
`timescale 1ns/100ps
`default_nettype none
module tb_rsc_cmd_unit
   import rsc_pkg::*;
   ();
   logic               mclk = 1'b0;
   logic               resetn = 1'b0;
   rsc_pins_t          pins;
   rsc_miso_t          miso;
   logic signed [15:0] raw_sample = 16'h0000;
   logic               raw_valid = 1'b1;
   logic               raw_ready;
   logic [7:0]         status_flags = STATUS_ALL_OK;
   logic               startup_done = 1'b0;
   logic               rec_error_evt = 1'b0;
   logic               lock_enabled;
   logic               highpass_init_hold;
   logic               rec_error;
   logic [7:0]         rx_byte;
   logic               rx_stb;
   logic [7:0]         exp_q[$];
   logic [7:0]         prev = RESP_RESET;
   logic [7:0]         rnd;
   integer             err_count = 0;
   integer             compares = 0;
   integer             cycles = 0;
   integer             seed = 32'h98CF;

   always #4 mclk = ~mclk;

   rsc_cmd_unit i_dut (
      .mclk(mclk), .resetn(resetn), .pins(pins), .miso(miso),
      .raw_sample(raw_sample), .raw_valid(raw_valid),
      .raw_ready(raw_ready), .status_flags(status_flags),
      .startup_done(startup_done), .rec_error_evt(rec_error_evt),
      .lock_enabled(lock_enabled),
      .highpass_init_hold(highpass_init_hold), .rec_error(rec_error));

   rsc_spi_master i_master (
      .mclk(mclk), .pins(pins), .miso(miso),
      .rx_byte(rx_byte), .rx_stb(rx_stb));

   // ****
   // Tasks
   // ****
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      compares++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Frame whose own answer is a, shown in the next frame
   task automatic cmd(input logic [15:0] w, input int n,
                      input logic [7:0] a);
      if (n >= 8)
      begin
         exp_q.push_back(prev);
         prev = a;
      end
      fork
         i_master.xfer(w, n);
         begin
            repeat (40) @(posedge mclk);
            chk("raw_ready", 8'h00, {7'h00, raw_ready});
         end
      join
   endtask

   task automatic unlock(input logic [7:0] ad, input logic stray);
      cmd({ADDR_UNLOCK_ONE, CMD_UNLOCK_ONE}, 16, RESP_ACK);
      cmd({ad, CMD_UNLOCK_TWO}, 16, RESP_ACK);
      if (stray)
         cmd({8'h00, CMD_STATUS_READ}, 8, STATUS_ALL_OK);
      cmd({ADDR_UNLOCK_THREE, CMD_UNLOCK_THREE}, 16, RESP_ACK);
   endtask

   // ****
   // Answer watcher and timeout
   // ****
   always @(posedge mclk)
   begin
      cycles++;
      if (rx_stb)
         chk("answer", exp_q.pop_front(), rx_byte);
      if (cycles == 40000)
      begin
         err_count++;
         test_done();
      end
   end

   // ****
   // Sequence
   // ****
   initial
   begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("lock", 8'h01, {7'h00, lock_enabled});
      cmd({8'h00, CMD_RATE_HIGH_READ}, 8, RESP_ERROR);
      cmd({8'h00, CMD_RATE_LOW_READ}, 8, RESP_ERROR);
      startup_done <= 1'b1;
      repeat (50) @(posedge mclk);
      cmd({8'h00, CMD_RATE_HIGH_READ}, 8, 8'h00);
      cmd({8'h00, CMD_RATE_LOW_READ}, 8, 8'h54);
      rnd = 8'($random(seed)) & 8'hFE;
      status_flags <= rnd;
      cmd({8'h00, CMD_STATUS_READ}, 8, rnd);
      cmd({8'h00, CMD_RATE_HIGH_READ}, 8, RESP_ERROR);
      cmd({8'h00, CMD_RATE_LOW_READ}, 8, RESP_ERROR);
      status_flags <= STATUS_ALL_OK;
      cmd(16'h0000, 8, RESP_ERROR);
      cmd({8'h00, CMD_STATUS_READ}, 5, 8'h00);
      rec_error_evt <= 1'b1;
      @(posedge mclk) rec_error_evt <= 1'b0;
      cmd({8'h00, CMD_PROC_REENABLE}, 8, RESP_ERROR);
      cmd({8'h01, CMD_HIGHPASS_INIT}, 16, RESP_ERROR);
      chk("rec_error", 8'h01, {7'h00, rec_error});
      chk("hold", 8'h00, {7'h00, highpass_init_hold});
      unlock(8'h51, 1'b0);
      chk("lock", 8'h01, {7'h00, lock_enabled});
      unlock(ADDR_UNLOCK_TWO, 1'b1);
      chk("lock", 8'h01, {7'h00, lock_enabled});
      unlock(ADDR_UNLOCK_TWO, 1'b0);
      chk("lock", 8'h00, {7'h00, lock_enabled});
      cmd({8'h00, CMD_PROC_REENABLE}, 8, RESP_ACK);
      chk("rec_error", 8'h00, {7'h00, rec_error});
      cmd({8'h01, CMD_HIGHPASS_INIT}, 16, RESP_ACK);
      chk("hold", 8'h01, {7'h00, highpass_init_hold});
      cmd({8'h00, CMD_RATE_HIGH_READ}, 8, RESP_ERROR);
      cmd({8'h00, CMD_HIGHPASS_INIT}, 16, RESP_ACK);
      chk("hold", 8'h00, {7'h00, highpass_init_hold});
      cmd({8'h00, CMD_LOCK_ENABLE}, 8, RESP_ACK);
      chk("lock", 8'h01, {7'h00, lock_enabled});
      cmd({8'h01, CMD_HIGHPASS_INIT}, 16, RESP_ERROR);
      chk("hold", 8'h00, {7'h00, highpass_init_hold});
      cmd({8'h00, CMD_RATE_HIGH_READ}, 8, 8'h00);
      cmd({8'h00, CMD_STATUS_READ}, 8, STATUS_ALL_OK);
      // One more frame brings the last status answer out
      cmd({8'h00, CMD_LOCK_ENABLE}, 8, RESP_ACK);
      repeat (10) @(posedge mclk);
      test_done();
   end
endmodule // tb_rsc_cmd_unit
`default_nettype wire
